// ### design/cct_translator.sv
/*
 * converter code translator: re-codes one converter word per valid pulse.
 * binary formats share a canonical offset-binary form; bcd formats share plain bcd.
 * assumes inputs come from logic on i_ref_clk; no synchroniser is placed here.
 */
`timescale 1ns/1ps
module cct_translator #(
	parameter int unsigned N_BITS   = cct_pkg::BIN_BITS_DEF,
	parameter int unsigned D_DIGITS = cct_pkg::BCD_DIGITS,
	parameter bit          OVR_EN   = 1'b1
) (
	input  wire logic                               i_ref_clk,
	input  wire logic                               i_nrst,
	input  wire logic                               i_clk_en,
	input  wire logic                               i_srst,
	input  wire logic                               i_valid,
	input  wire logic [2:0]                         i_src_fmt,
	input  wire logic [2:0]                         i_dst_fmt,
	input  wire logic [N_BITS-1:0]                  i_bin_word,
	input  wire logic [D_DIGITS*4:0]                i_bcd_word,
	output logic                                    o_valid,
	output logic [N_BITS-1:0]                       o_bin_word,
	output logic [D_DIGITS*4:0]                     o_bcd_word,
	output logic                                    o_invalid
);

	localparam int unsigned BW = D_DIGITS * cct_pkg::NIBBLE_BITS;

	// ********************************************************************
	// width check
	// ********************************************************************
	// width from one to twenty
	initial begin
		if (N_BITS < 1 || N_BITS > cct_pkg::BIN_BITS_MAX) begin
			$error("binary width out of range");
		end
	end

	// ********************************************************************
	// binary path: everything goes through offset binary
	// ********************************************************************
	// bit numbering
	// bit N_BITS-1 is position 1 (leftmost, weight one half); bit 0 is position n
	logic [N_BITS-1:0] canon;
	logic              canon_neg_fs;
	logic [N_BITS-1:0] bin_nxt;
	logic              bin_bad;
	logic [N_BITS-1:0] mag;
	logic [N_BITS-1:0] mag_neg;

	always_comb begin
		canon = i_bin_word;
		mag   = '0;
		case (cct_pkg::cct_fmt_t'(i_src_fmt))
			cct_pkg::CCT_STRAIGHT:    canon = i_bin_word;
			cct_pkg::CCT_OFFSET:      canon = i_bin_word;
			cct_pkg::CCT_COMP_BIN:    canon = ~i_bin_word;
			cct_pkg::CCT_COMP_OFFSET: canon = ~i_bin_word;
			cct_pkg::CCT_TWOS:        canon = {~i_bin_word[N_BITS-1], i_bin_word[N_BITS-2:0]};
			cct_pkg::CCT_SIGN_MAG: begin
				// both zeros land on offset zero
				mag = {1'b0, i_bin_word[N_BITS-2:0]};
				if (i_bin_word[N_BITS-1]) begin
					canon = {1'b1, i_bin_word[N_BITS-2:0]};
				end else begin
					canon = {1'b1, {(N_BITS-1){1'b0}}} - mag;
				end
			end
			default:                  canon = i_bin_word;
		endcase
	end

	// all zeros in offset form is negative full scale
	assign canon_neg_fs = (canon == '0);

	always_comb begin
		bin_bad = 1'b0;
		mag_neg = '0;
		bin_nxt = canon;
		case (cct_pkg::cct_fmt_t'(i_dst_fmt))
			// all ones stays one step short of full scale
			cct_pkg::CCT_STRAIGHT:    bin_nxt = canon;
			cct_pkg::CCT_OFFSET:      bin_nxt = canon;
			cct_pkg::CCT_COMP_BIN:    bin_nxt = ~canon;
			cct_pkg::CCT_COMP_OFFSET: bin_nxt = ~canon;
			// sign flip gives true two's complement
			cct_pkg::CCT_TWOS:        bin_nxt = {~canon[N_BITS-1], canon[N_BITS-2:0]};
			cct_pkg::CCT_SIGN_MAG: begin
				// sign one is positive, magnitude below
				if (canon[N_BITS-1]) begin
					bin_nxt = canon;
				end else if (canon_neg_fs) begin
					// saturate negative full scale and flag it
					bin_bad = 1'b1;
					bin_nxt = {1'b0, {(N_BITS-1){1'b1}}};
				end else begin
					mag_neg = {1'b1, {(N_BITS-1){1'b0}}} - canon;
					bin_nxt = {1'b0, mag_neg[N_BITS-2:0]};
				end
			end
			default:                  bin_bad = 1'b1;
		endcase
	end

	// ********************************************************************
	// decimal path
	// ********************************************************************
	logic          src_bcd;
	logic          dst_bcd;
	logic [BW:0]   bcd_plain;
	logic [BW:0]   bcd_nxt;
	logic          nib_bad;

	assign src_bcd = (i_src_fmt == cct_pkg::CCT_BCD) || (i_src_fmt == cct_pkg::CCT_COMP_BCD);
	assign dst_bcd = (i_dst_fmt == cct_pkg::CCT_BCD) || (i_dst_fmt == cct_pkg::CCT_COMP_BCD);

	always_comb begin
		// complementary bcd is the bitwise inverse
		bcd_plain = (i_src_fmt == cct_pkg::CCT_COMP_BCD) ?
			{i_bcd_word[BW], ~i_bcd_word[BW-1:0]} : i_bcd_word;
		if (!OVR_EN) begin
			bcd_plain[BW] = 1'b0;
		end
		nib_bad = 1'b0;
		for (int k = 0; k < D_DIGITS; k++) begin
			if (bcd_plain[k*4 +: 4] > cct_pkg::NIBBLE_MAX) begin
				nib_bad = 1'b1;
			end
		end
		// one step is one count of the lowest digit
		bcd_nxt = (i_dst_fmt == cct_pkg::CCT_COMP_BCD) ?
			{bcd_plain[BW], ~bcd_plain[BW-1:0]} : bcd_plain;
	end

	// ********************************************************************
	// output registers
	// ********************************************************************
	// one enabled edge after input valid; cleared by i_nrst, or by i_srst only while i_clk_en is high
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_valid    <= cct_pkg::VALID_RST;
			o_bin_word <= '0;
			o_bcd_word <= '0;
			o_invalid  <= 1'b0;
		end else if (i_clk_en) begin
			if (i_srst) begin
				o_valid    <= cct_pkg::VALID_RST;
				o_bin_word <= '0;
				o_bcd_word <= '0;
				o_invalid  <= 1'b0;
			end else begin
				o_valid <= i_valid;
				if (i_valid) begin
					o_bin_word <= bin_nxt;
					o_bcd_word <= bcd_nxt;
					// bad nibble or no target code; binary-decimal mixes unsupported
					o_invalid  <= src_bcd ? (nib_bad || !dst_bcd) :
						(dst_bcd || bin_bad);
				end
			end
		end
	end

	// ********************************************************************
	// checks
	// ********************************************************************
	a_valid_follows: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_clk_en && !i_srst && i_valid) |=> o_valid)
		else $error("valid did not follow input");
	a_valid_single: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_clk_en && !i_valid) |=> !o_valid)
		else $error("valid stood longer than one cycle");
	a_srst_clears: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_clk_en && i_srst) |=> (!o_valid && !o_invalid && o_bin_word == '0))
		else $error("sync reset did not clear");
	a_comp_bin_inv: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_clk_en && !i_srst && i_valid && i_src_fmt == cct_pkg::CCT_STRAIGHT
		&& i_dst_fmt == cct_pkg::CCT_COMP_BIN) |=> o_bin_word == ~$past(i_bin_word))
		else $error("complementary binary wrong");
	a_twos_msb: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_clk_en && !i_srst && i_valid && i_src_fmt == cct_pkg::CCT_OFFSET
		&& i_dst_fmt == cct_pkg::CCT_TWOS)
		|=> o_bin_word == ($past(i_bin_word) ^ {1'b1, {(N_BITS-1){1'b0}}}))
		else $error("two's complement sign flip wrong");
	a_twos_clean: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_clk_en && !i_srst && i_valid && i_src_fmt == cct_pkg::CCT_OFFSET
		&& i_dst_fmt == cct_pkg::CCT_TWOS) |=> !o_invalid)
		else $error("representable binary word flagged");
	a_negfs_flag: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_clk_en && !i_srst && i_valid && i_src_fmt == cct_pkg::CCT_OFFSET
		&& i_dst_fmt == cct_pkg::CCT_SIGN_MAG && i_bin_word == '0) |=> o_invalid)
		else $error("negative full scale not flagged");
	a_smag_zero: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_clk_en && !i_srst && i_valid && i_src_fmt == cct_pkg::CCT_SIGN_MAG
		&& i_dst_fmt == cct_pkg::CCT_OFFSET && i_bin_word[N_BITS-2:0] == '0)
		|=> o_bin_word == {1'b1, {(N_BITS-1){1'b0}}})
		else $error("sign-magnitude zero wrong");
	a_mixed_flag: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_clk_en && !i_srst && i_valid && i_src_fmt == cct_pkg::CCT_STRAIGHT
		&& i_dst_fmt == cct_pkg::CCT_BCD) |=> o_invalid)
		else $error("binary to decimal not flagged");
	a_nibble_bad: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_clk_en && !i_srst && i_valid && i_src_fmt == cct_pkg::CCT_BCD
		&& i_dst_fmt == cct_pkg::CCT_BCD && i_bcd_word[3:0] > cct_pkg::NIBBLE_MAX)
		|=> o_invalid)
		else $error("bad nibble not flagged");
	a_comp_bcd: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_clk_en && !i_srst && i_valid && i_src_fmt == cct_pkg::CCT_BCD
		&& i_dst_fmt == cct_pkg::CCT_COMP_BCD)
		|=> o_bcd_word[BW-1:0] == ~$past(i_bcd_word[BW-1:0]))
		else $error("complementary bcd wrong");
	a_ovr_pass: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_clk_en && !i_srst && i_valid && i_src_fmt == cct_pkg::CCT_BCD
		&& i_dst_fmt == cct_pkg::CCT_COMP_BCD)
		|=> o_bcd_word[BW] == (OVR_EN && $past(i_bcd_word[BW])))
		else $error("over-range bit not passed");

endmodule

// ### design/cct_pkg.sv
/*
 * constants and enumerations shared by the converter code translator.
 * assumes a single 40 MHz clock domain; words arrive from logic on that clock.
 */
// What this block does
// - straight binary: leftmost bit weighs half full scale, each next bit half that
// - bit 1 is the leftmost, most significant; bit n is the least significant
// - all-ones straight binary is one step below full scale, never full scale
// - complementary binary inverts every straight binary bit
// - offset binary: one then zeros is zero, all zeros negative full scale
// - two's complement is offset binary with the top bit inverted
// - two's complement words of equal opposite magnitude sum to zero with carry
// - complementary offset binary inverts offset binary; zero is zero then ones
// - sign-magnitude: equal magnitudes share low bits; sign one means positive
// - both sign-magnitude zeros, positive and negative, decode as zero
// - sign-magnitude cannot hold negative full scale; flag and saturate it
// - bcd uses four bits per digit, values zero to nine only
// - complementary bcd inverts every bcd bit
// - decimal step is range over ten to the digit count, digits a parameter
// - binary width may be any value from one to twenty bits
// - optional over-range bit above the bcd digits, weighted at full scale
package cct_pkg;

	localparam int unsigned BIN_BITS_DEF  = 8;
	localparam int unsigned BIN_BITS_MAX  = 20;
	localparam int unsigned BCD_DIGITS    = 3;
	localparam int unsigned NIBBLE_BITS   = 4;
	localparam logic [3:0]  NIBBLE_MAX    = 4'h9;
	localparam logic        VALID_RST     = 1'b0;

	// format codes; order follows the usual path of a bipolar chain
	typedef enum logic [2:0] {
		CCT_STRAIGHT     = 3'b000,
		CCT_COMP_BIN     = 3'b001,
		CCT_OFFSET       = 3'b011,
		CCT_COMP_OFFSET  = 3'b010,
		CCT_TWOS         = 3'b110,
		CCT_SIGN_MAG     = 3'b111,
		CCT_BCD          = 3'b101,
		CCT_COMP_BCD     = 3'b100
	} cct_fmt_t;

endpackage

// ### tb/cct_conv_port.sv
/*
 * model of the converter data port: presents one word for one cycle per request.
 * assumes requests are raised just after the rising edge of i_ref_clk.
 */
`timescale 1ns/1ps
module cct_conv_port (
	input  wire logic        i_ref_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_go,
	input  wire logic [7:0]  i_bin,
	input  wire logic [12:0] i_bcd,
	output logic             o_valid,
	output logic [7:0]       o_bin,
	output logic [12:0]      o_bcd
);
	// between words the lines flip every cycle between the last word and its inverse, so a stale read shows up
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_valid <= 1'b0;
			o_bin   <= 8'h00;
			o_bcd   <= 13'h0000;
		end else begin
			o_valid <= i_go;
			o_bin   <= i_go ? i_bin : ~o_bin;
			o_bcd   <= i_go ? i_bcd : ~o_bcd;
		end
	end
endmodule

// ### tb/cct_translator_test.sv
/*
 * self-checking bench for the converter code translator, 8 bits and 3 digits.
 * assumes the translator answers one edge after it takes a word.
 */
`timescale 1ns/1ps
module cct_translator_test;
	localparam logic [2:0] SB = cct_pkg::CCT_STRAIGHT, CB = cct_pkg::CCT_COMP_BIN;
	localparam logic [2:0] OB = cct_pkg::CCT_OFFSET, COB = cct_pkg::CCT_COMP_OFFSET;
	localparam logic [2:0] TC = cct_pkg::CCT_TWOS, SM = cct_pkg::CCT_SIGN_MAG;
	localparam logic [2:0] BC = cct_pkg::CCT_BCD, CBC = cct_pkg::CCT_COMP_BCD;
	logic        clk, nrst, clk_en, srst, go, valid, ovalid, oinv;
	logic [2:0]  src, dst;
	logic [7:0]  pbin, bin, obin;
	logic [12:0] pbcd, bcd, obcd;
	int          fail_count, checked;

	cct_conv_port port_u (.i_ref_clk(clk), .i_nrst(nrst), .i_go(go), .i_bin(pbin),
		.i_bcd(pbcd), .o_valid(valid), .o_bin(bin), .o_bcd(bcd));
	cct_translator #(.N_BITS(8), .D_DIGITS(3), .OVR_EN(1'b1)) dut_u (.i_ref_clk(clk),
		.i_nrst(nrst), .i_clk_en(clk_en), .i_srst(srst), .i_valid(valid), .i_src_fmt(src),
		.i_dst_fmt(dst), .i_bin_word(bin), .i_bcd_word(bcd), .o_valid(ovalid),
		.o_bin_word(obin), .o_bcd_word(obcd), .o_invalid(oinv));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task end_of_test;
		$display("checked %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task chk(input string name, input logic [12:0] exp, input logic [12:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	// ************************************
	// one word through, mode 0 bin, 1 bcd, 2 word not judged
	// ************************************
	task run(input logic [2:0] s, d, input logic [12:0] w, e, input logic inv, input int m);
		src = s;
		dst = d;
		pbin = w[7:0];
		pbcd = w;
		go = 1'b1;
		@(posedge clk);
		#1 go = 1'b0;
		@(posedge clk);
		#1 chk("valid", 13'h0001, {12'h000, ovalid});
		chk("invalid", {12'h000, inv}, {12'h000, oinv});
		if (m < 2) chk("word", e, m == 1 ? obcd : {5'h00, obin});
		@(posedge clk);
		#1 chk("valid off", 13'h0000, {12'h000, ovalid});
	endtask

	task t_unipolar;
		run(SB, CB, 13'h00ff, 13'h0000, 1'b0, 0);
		run(SB, CB, 13'h0000, 13'h00ff, 1'b0, 0);
		run(CB, SB, 13'h00bf, 13'h0040, 1'b0, 0);
		run(CB, SB, 13'h00fe, 13'h0001, 1'b0, 0);
		$display("unipolar test done");
	endtask

	task t_bipolar;
		run(OB, TC, 13'h0080, 13'h0000, 1'b0, 0);
		run(OB, TC, 13'h0000, 13'h0080, 1'b0, 0);
		run(OB, TC, 13'h00e0, 13'h0060, 1'b0, 0);
		run(OB, TC, 13'h0020, 13'h00a0, 1'b0, 0);
		run(OB, COB, 13'h0080, 13'h007f, 1'b0, 0);
		run(TC, SM, 13'h00e0, 13'h0020, 1'b0, 0);
		run(OB, SM, 13'h00ff, 13'h00ff, 1'b0, 0);
		$display("bipolar test done");
	endtask

	task t_signmag;
		run(SM, OB, 13'h0000, 13'h0080, 1'b0, 0);
		run(SM, OB, 13'h0080, 13'h0080, 1'b0, 0);
		run(OB, SM, 13'h0000, 13'h007f, 1'b1, 0);
		$display("sign magnitude test done");
	endtask

	task t_bcd;
		run(BC, CBC, 13'h0999, 13'h0666, 1'b0, 1);
		run(BC, CBC, 13'h1000, 13'h1fff, 1'b0, 1);
		run(CBC, BC, 13'h0eda, 13'h0125, 1'b0, 1);
		run(BC, CBC, 13'h00a0, 13'h0000, 1'b1, 2);
		run(SB, BC, 13'h0012, 13'h0000, 1'b1, 2);
		$display("bcd test done");
	endtask

	// ************************************
	// freeze with a word standing, sync reset, async reset in mid-run
	// ************************************
	task t_control;
		src = SB;
		dst = CB;
		pbin = 8'h0f;
		go = 1'b1;
		@(posedge clk);
		#1 go = 1'b0;
		@(posedge clk);
		// the translator has just taken 0x0f; freeze while its answer stands
		#1 clk_en = 1'b0;
		pbin = 8'h55;
		go = 1'b1;
		@(posedge clk);
		#1 go = 1'b0;
		@(posedge clk);
		#1 chk("frozen valid", 13'h0001, {12'h000, ovalid});
		chk("frozen word", 13'h00f0, {5'h00, obin});
		clk_en = 1'b1;
		@(posedge clk);
		#1 chk("valid after freeze", 13'h0000, {12'h000, ovalid});
		chk("word after freeze", 13'h00f0, {5'h00, obin});
		run(SB, CB, 13'h0000, 13'h00ff, 1'b0, 0);
		srst = 1'b1;
		@(posedge clk);
		#1 srst = 1'b0;
		chk("cleared word", 13'h0000, {5'h00, obin});
		run(OB, SM, 13'h0000, 13'h007f, 1'b1, 0);
		nrst = 1'b0;
		@(posedge clk);
		#1 chk("reset invalid", 13'h0000, {12'h000, oinv});
		chk("reset word", 13'h0000, {5'h00, obin});
		nrst = 1'b1;
		@(posedge clk);
		#1 chk("valid after reset", 13'h0000, {12'h000, ovalid});
		$display("control test done");
	endtask

	initial begin
		{nrst, clk_en, srst, go, src, dst, pbin, pbcd} = '0;
		fail_count = 0;
		checked = 0;
		repeat (12) @(posedge clk);
		#1 nrst = 1'b1;
		clk_en = 1'b1;
		chk("reset valid", 13'h0000, {12'h000, ovalid});
		t_unipolar();
		t_bipolar();
		t_signmag();
		t_bcd();
		t_control();
		end_of_test();
	end
endmodule
